// File: rtl/exc_unit.sv
// Contract
// - trap pushes address of following instruction
// - trap vector taken from trap instruction
// - push status, push counter, fetch, plain jump
// - undefined code in slot raises slot exception
// - counter-rewriting instruction in slot raises it too
// - slot exception pushes delayed branch target
// - undefined code elsewhere pushes its own address
// - blocked address errors and interrupts stay pending
// - delay slot accepts no address error, interrupt
// - after control transfer, interrupts wait, errors not
// - misaligned stack pointer raises address error
// - stacking address error taken after current processing
// - address error stacking ignores further address errors
// - misaligned writes still issued, pointer minus four
// - address error waits for current instruction end
`timescale 1ns/1ns
`default_nettype none
`include "exc_regs.svh"

module exc_unit
  import exc_pkg::*;
#(
  parameter logic [7:0] VEC_ILLEGAL = 8'h10, // arbitrary
  parameter logic [7:0] VEC_SLOT    = 8'h11, // arbitrary
  parameter logic [7:0] VEC_ADDR    = 8'h12  // arbitrary
) (
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic        DEC_VALID,
  input  wire logic [31:0] DEC_ADDR,
  input  wire logic [31:0] DEC_NEXT_PC,
  input  wire logic [31:0] DEC_BRANCH_TARGET,
  input  wire logic        DEC_UNDEF,
  input  wire logic        DEC_DELAYED_BRANCH,
  input  wire logic        DEC_PC_WRITE,
  input  wire logic        DEC_TRAP,
  input  wire logic [7:0]  DEC_TRAP_VEC,
  input  wire logic        DEC_CTRL_XFER,
  input  wire logic [31:0] STATUS_WORD,
  input  wire logic [31:0] STACK_POINTER,
  input  wire logic [31:0] VECTOR_BASE,
  input  wire logic        INT_REQ,
  input  wire logic [7:0]  INT_VEC,
  input  wire logic        ADDR_ERR,
  input  wire logic        BUS_ACK,
  input  wire logic [31:0] BUS_RDATA,
  output logic             BUS_REQ,
  output logic             BUS_WRITE,
  output logic [31:0]      BUS_ADDR,
  output logic [31:0]      BUS_WDATA,
  output logic             EXC_BUSY,
  output logic             INT_ACK,
  output logic             JUMP_VALID,
  output logic [31:0]      JUMP_ADDR,
  output logic             SP_WRITE,
  output logic [31:0]      SP_NEW
);

  function automatic logic [31:0] sp_step(input logic [31:0] a);
    sp_step = a - `STACK_STEP;
  endfunction

  function automatic logic misaligned(input logic [31:0] a);
    misaligned = |a[1:0];
  endfunction

  function automatic logic [31:0] vec_entry(input logic [31:0] base, input logic [7:0] v);
    vec_entry = base + {22'h0, v, 2'h0};
  endfunction

  state_e      state_q, state_d;
  kind_e       kind_q, kind_d, kind;
  logic [31:0] sp_q, sp_d, vbase_q, vbase_d, pc_save_q, pc_save_d;
  logic [31:0] btarget_q, btarget_d, target_q, target_d;
  logic [7:0]  vec_q, vec_d;
  logic        ae_pend_q, ae_pend_d, slot_q, slot_d, after_q, after_d;
  logic        req_q, req_d, wr_q, wr_d, busy_q, busy_d, iack_q, iack_d;
  logic        jv_q, jv_d;
  logic [31:0] addr_q, addr_d, wdata_q, wdata_d;

  exc_accept u_accept (
    .clk        (CLOCK),
    .arst_n     (ARST_N),
    .valid      (DEC_VALID && state_q == S_IDLE),
    .slot       (slot_q),
    .after_ctrl (after_q),
    .ae_pend    (ae_pend_q),
    .int_req    (INT_REQ),
    .undef      (DEC_UNDEF),
    .pc_write   (DEC_PC_WRITE),
    .trap       (DEC_TRAP),
    .kind       (kind)
  );

  always_comb begin
    state_d   = state_q;
    kind_d    = kind_q;
    sp_d      = sp_q;
    vbase_d   = vbase_q;
    pc_save_d = pc_save_q;
    btarget_d = btarget_q;
    target_d  = target_q;
    vec_d     = vec_q;
    ae_pend_d = ae_pend_q;
    slot_d    = slot_q;
    after_d   = after_q;
    req_d     = req_q;
    wr_d      = wr_q;
    addr_d    = addr_q;
    wdata_d   = wdata_q;
    busy_d    = busy_q;
    iack_d    = 1'b0;
    jv_d      = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (DEC_VALID && kind != K_NONE) begin
          state_d   = S_PUSH_SR;
          kind_d    = kind;
          busy_d    = 1'b1;
          sp_d      = STACK_POINTER;
          vbase_d   = VECTOR_BASE;
          req_d     = 1'b1;
          wr_d      = 1'b1;
          addr_d    = sp_step(STACK_POINTER);
          wdata_d   = STATUS_WORD;
          slot_d    = 1'b0;
          after_d   = 1'b0;
          pc_save_d = DEC_ADDR;
          unique case (kind)
            K_TRAP: begin
              pc_save_d = DEC_NEXT_PC;
              vec_d     = DEC_TRAP_VEC;
            end
            K_SLOT: begin
              pc_save_d = btarget_q;
              vec_d     = VEC_SLOT;
            end
            K_ILLEGAL: vec_d = VEC_ILLEGAL;
            K_ADDR: begin
              vec_d     = VEC_ADDR;
              ae_pend_d = 1'b0;
            end
            K_INT: begin
              vec_d  = INT_VEC;
              iack_d = 1'b1;
            end
            default: vec_d = vec_q;
          endcase
        end else if (DEC_VALID) begin
          slot_d    = DEC_DELAYED_BRANCH;
          btarget_d = DEC_BRANCH_TARGET;
          after_d   = DEC_CTRL_XFER;
        end
      end
      S_PUSH_SR: begin
        if (BUS_ACK) begin
          state_d = S_PUSH_PC;
          sp_d    = addr_q;
          addr_d  = sp_step(addr_q);
          wdata_d = pc_save_q;
          if (misaligned(addr_q) && kind_q != K_ADDR) begin
            ae_pend_d = 1'b1;
          end
        end
      end
      S_PUSH_PC: begin
        if (BUS_ACK) begin
          state_d = S_FETCH;
          sp_d    = addr_q;
          wr_d    = 1'b0;
          addr_d  = vec_entry(vbase_q, vec_q);
          if ((misaligned(addr_q) || misaligned(vbase_q)) && kind_q != K_ADDR) begin
            ae_pend_d = 1'b1;
          end
        end
      end
      S_FETCH: begin
        if (BUS_ACK) begin
          state_d  = S_JUMP;
          req_d    = 1'b0;
          target_d = BUS_RDATA;
        end
      end
      S_JUMP: begin
        state_d = S_IDLE;
        jv_d    = 1'b1;
        busy_d  = 1'b0;
      end
      default: state_d = S_IDLE;
    endcase
    // a bus fault is kept even in the cycle its pending flag is consumed
    if (ADDR_ERR && !(busy_q && kind_q == K_ADDR)) begin
      ae_pend_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q   <= S_IDLE;
      kind_q    <= K_NONE;
      sp_q      <= `WORD_RESET;
      vbase_q   <= `WORD_RESET;
      pc_save_q <= `WORD_RESET;
      btarget_q <= `WORD_RESET;
      target_q  <= `WORD_RESET;
      vec_q     <= `VEC_RESET;
      ae_pend_q <= 1'b0;
      slot_q    <= 1'b0;
      after_q   <= 1'b0;
      req_q     <= 1'b0;
      wr_q      <= 1'b0;
      addr_q    <= `WORD_RESET;
      wdata_q   <= `WORD_RESET;
      busy_q    <= 1'b0;
      iack_q    <= 1'b0;
      jv_q      <= 1'b0;
    end else begin
      state_q   <= state_d;
      kind_q    <= kind_d;
      sp_q      <= sp_d;
      vbase_q   <= vbase_d;
      pc_save_q <= pc_save_d;
      btarget_q <= btarget_d;
      target_q  <= target_d;
      vec_q     <= vec_d;
      ae_pend_q <= ae_pend_d;
      slot_q    <= slot_d;
      after_q   <= after_d;
      req_q     <= req_d;
      wr_q      <= wr_d;
      addr_q    <= addr_d;
      wdata_q   <= wdata_d;
      busy_q    <= busy_d;
      iack_q    <= iack_d;
      jv_q      <= jv_d;
    end
  end

  assign BUS_REQ    = req_q;
  assign BUS_WRITE  = wr_q;
  assign BUS_ADDR   = addr_q;
  assign BUS_WDATA  = wdata_q;
  assign EXC_BUSY   = busy_q;
  assign INT_ACK    = iack_q;
  assign JUMP_VALID = jv_q;
  assign JUMP_ADDR  = target_q;
  assign SP_WRITE   = jv_q;
  assign SP_NEW     = sp_q;

  sequence take_s(kind_e k);
    state_q == S_IDLE && DEC_VALID && kind == k;
  endsequence

  sequence fetch_done_s;
    state_q == S_FETCH && BUS_ACK;
  endsequence

  a_trap_pc_vec: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    take_s(K_TRAP) |=> pc_save_q == $past(DEC_NEXT_PC) && vec_q == $past(DEC_TRAP_VEC))
    else $error("trap stacked value or vector wrong");

  a_slot_pc_target: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    take_s(K_SLOT) |=> pc_save_q == $past(btarget_q) && BUS_WDATA == $past(STATUS_WORD))
    else $error("slot exception stacked value wrong");

  a_illegal_pc_addr: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    take_s(K_ILLEGAL) |=> pc_save_q == $past(DEC_ADDR) && vec_q == VEC_ILLEGAL)
    else $error("illegal instruction stacked value wrong");

  a_push_order: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (state_q == S_PUSH_SR && BUS_ACK) |=> state_q == S_PUSH_PC && BUS_WRITE
      && BUS_WDATA == pc_save_q && BUS_ADDR == $past(BUS_ADDR) - 32'h4)
    else $error("counter push not after status push");

  a_vec_addr: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (state_q == S_PUSH_PC && BUS_ACK) |=> !BUS_WRITE && BUS_REQ
      && BUS_ADDR == vbase_q + {22'h0, vec_q, 2'h0})
    else $error("vector entry address wrong");

  a_jump_after: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    fetch_done_s ##1 1'b1 |=> JUMP_VALID && JUMP_ADDR == $past(BUS_RDATA, 2) ##1 !JUMP_VALID)
    else $error("handler jump wrong");

  a_stack_misalign: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (state_q == S_PUSH_SR && BUS_ACK && BUS_ADDR[1:0] != 2'h0 && kind_q != K_ADDR)
      |=> ae_pend_q)
    else $error("stacking address error lost");

  a_ae_ignored: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (busy_q && kind_q == K_ADDR && !ae_pend_q) |=> !ae_pend_q)
    else $error("address error raised during its own stacking");

  a_ae_pending: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (ADDR_ERR && !busy_q) |=> ae_pend_q)
    else $error("address error not held pending");

endmodule

`default_nettype wire

// File: rtl/exc_regs.svh
`ifndef EXC_REGS_SVH
`define EXC_REGS_SVH

// stack grows down one longword per pushed item
`define STACK_STEP   32'h0000_0004
// vector table entries are longwords
`define VEC_SCALE    2
`define WORD_RESET   32'h0000_0000
`define VEC_RESET    8'h00

`endif

// File: rtl/exc_pkg.sv
package exc_pkg;

  typedef enum logic [4:0] {
    S_IDLE    = 5'h01,
    S_PUSH_SR = 5'h02,
    S_PUSH_PC = 5'h04,
    S_FETCH   = 5'h08,
    S_JUMP    = 5'h10
  } state_e;

  typedef enum logic [2:0] {
    K_NONE    = 3'h0,
    K_TRAP    = 3'h1,
    K_SLOT    = 3'h2,
    K_ILLEGAL = 3'h3,
    K_ADDR    = 3'h4,
    K_INT     = 3'h5
  } kind_e;

endpackage

// File: rtl/exc_accept.sv
`timescale 1ns/1ns
`default_nettype none

module exc_accept
  import exc_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic valid,
  input  wire logic slot,
  input  wire logic after_ctrl,
  input  wire logic ae_pend,
  input  wire logic int_req,
  input  wire logic undef,
  input  wire logic pc_write,
  input  wire logic trap,
  output var kind_e kind
);

  // pending sources go ahead of the decoded instruction, which is then not executed
  always_comb begin
    kind = K_NONE;
    if (valid) begin
      if (ae_pend && !slot) begin
        kind = K_ADDR;
      end else if (int_req && !slot && !after_ctrl) begin
        kind = K_INT;
      end else if (slot && (undef || pc_write)) begin
        kind = K_SLOT;
      end else if (undef) begin
        kind = K_ILLEGAL;
      end else if (trap) begin
        kind = K_TRAP;
      end
    end
  end

  a_slot_defers: assert property (@(posedge clk) disable iff (!arst_n)
    (valid && slot) |-> (kind != K_ADDR && kind != K_INT))
    else $error("exception taken in delay slot");

  a_ctrl_defers_int: assert property (@(posedge clk) disable iff (!arst_n)
    (valid && after_ctrl && !slot) |-> (kind != K_INT && (!ae_pend || kind == K_ADDR)))
    else $error("wrong acceptance after control register transfer");

  a_slot_illegal: assert property (@(posedge clk) disable iff (!arst_n)
    (valid && slot && (undef || pc_write)) |-> (kind == K_SLOT))
    else $error("illegal slot not raised");

endmodule

`default_nettype wire

// File: testbench/bus_responder.sv
`timescale 1ns/1ns
`default_nettype none

module bus_responder (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        req,
  input  wire logic        write,
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  lat,
  output logic             ack,
  output logic [31:0]      rdata
);
  logic [3:0] cnt_q;

  // registered ack: never in the cycle the request first shows
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack   <= 1'b0;
      cnt_q <= 4'h0;
      rdata <= 32'h0;
    end else begin
      // read data is only meaningful with the ack, so it keeps moving
      rdata <= ~rdata;
      ack   <= 1'b0;
      if (req && !ack) begin
        if (cnt_q >= lat) begin
          ack   <= 1'b1;
          cnt_q <= 4'h0;
          if (!write) begin
            rdata <= ~addr;
          end
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// File: testbench/instruction_exception_gating_tb.sv
`timescale 1ns/1ns
`default_nettype none

module instruction_exception_gating_tb;
  import exc_pkg::*;
  localparam logic [7:0] V_ILL = 8'h10, V_SLOT = 8'h11, V_ADDR = 8'h12;
  logic        CLOCK, ARST_N, DEC_VALID, DEC_UNDEF, DEC_DELAYED_BRANCH, DEC_PC_WRITE;
  logic        DEC_TRAP, DEC_CTRL_XFER, INT_REQ, ADDR_ERR, BUS_ACK, BUS_REQ, BUS_WRITE;
  logic        EXC_BUSY, INT_ACK, JUMP_VALID, SP_WRITE;
  logic [7:0]  DEC_TRAP_VEC, INT_VEC;
  logic [31:0] DEC_ADDR, DEC_NEXT_PC, DEC_BRANCH_TARGET, STATUS_WORD, STACK_POINTER;
  logic [31:0] VECTOR_BASE, BUS_RDATA, BUS_ADDR, BUS_WDATA, JUMP_ADDR, SP_NEW, tgt;
  logic [3:0]  lat;
  logic [31:0] q[$];
  int          err_total, num_checks;

  exc_unit #(.VEC_ILLEGAL(V_ILL), .VEC_SLOT(V_SLOT), .VEC_ADDR(V_ADDR)) i_exc_unit (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .DEC_VALID(DEC_VALID), .DEC_ADDR(DEC_ADDR),
    .DEC_NEXT_PC(DEC_NEXT_PC), .DEC_BRANCH_TARGET(DEC_BRANCH_TARGET),
    .DEC_UNDEF(DEC_UNDEF), .DEC_DELAYED_BRANCH(DEC_DELAYED_BRANCH),
    .DEC_PC_WRITE(DEC_PC_WRITE), .DEC_TRAP(DEC_TRAP), .DEC_TRAP_VEC(DEC_TRAP_VEC),
    .DEC_CTRL_XFER(DEC_CTRL_XFER), .STATUS_WORD(STATUS_WORD),
    .STACK_POINTER(STACK_POINTER), .VECTOR_BASE(VECTOR_BASE), .INT_REQ(INT_REQ),
    .INT_VEC(INT_VEC), .ADDR_ERR(ADDR_ERR), .BUS_ACK(BUS_ACK), .BUS_RDATA(BUS_RDATA),
    .BUS_REQ(BUS_REQ), .BUS_WRITE(BUS_WRITE), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA),
    .EXC_BUSY(EXC_BUSY), .INT_ACK(INT_ACK), .JUMP_VALID(JUMP_VALID),
    .JUMP_ADDR(JUMP_ADDR), .SP_WRITE(SP_WRITE), .SP_NEW(SP_NEW));

  bus_responder i_bus_responder (.clk(CLOCK), .arst_n(ARST_N), .req(BUS_REQ),
    .write(BUS_WRITE), .addr(BUS_ADDR), .lat(lat), .ack(BUS_ACK), .rdata(BUS_RDATA));

  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // software keeps both pointers on longword boundaries here
  task env;
    STATUS_WORD = $urandom;
    STACK_POINTER = $urandom & 32'hFFFF_FFFC;
    VECTOR_BASE = $urandom & 32'hFFFF_FFFC;
    INT_VEC = 8'($urandom);
    lat = 4'($urandom_range(0, 3));
  endtask

  task dec(input logic u, input logic db, input logic pw, input logic tr, input logic cx);
    @(posedge CLOCK);
    #1;
    {DEC_VALID, DEC_UNDEF, DEC_DELAYED_BRANCH, DEC_PC_WRITE, DEC_TRAP} = {1'b1, u, db, pw, tr};
    DEC_CTRL_XFER = cx;
    ADDR_ERR = 1'b0;
    DEC_ADDR = $urandom & 32'hFFFF_FFFE;
    DEC_NEXT_PC = DEC_ADDR + 32'h2;
    DEC_BRANCH_TARGET = $urandom & 32'hFFFF_FFFE;
    DEC_TRAP_VEC = 8'($urandom);
  endtask

  task idle;
    @(posedge CLOCK);
    #1;
    DEC_VALID = 1'b0;
    ADDR_ERR = 1'b0;
  endtask

  task none_taken;
    idle;
    @(negedge CLOCK);
    chk("busy idle", EXC_BUSY, 1'b0);
    chk("int ack idle", INT_ACK, 1'b0);
  endtask

  task exc(input logic [7:0] v, input logic [31:0] pc, input logic intr);
    int ia;
    logic [31:0] e;
    ia = 0;
    e = VECTOR_BASE + {22'h0, v, 2'b00};
    q = {STACK_POINTER - 32'h4, 32'h1, STATUS_WORD, STACK_POINTER - 32'h8, 32'h1, pc, e, 32'h0, e};
    idle;
    @(negedge CLOCK);
    chk("busy", EXC_BUSY, 1'b1);
    repeat (300) begin
      if (INT_ACK) ia++;
      if (JUMP_VALID) break;
      if (BUS_REQ && BUS_ACK && q.size() > 2) begin
        chk("addr", BUS_ADDR, q.pop_front());
        chk("dir", BUS_WRITE, q.pop_front());
        e = q.pop_front();
        if (BUS_WRITE && STACK_POINTER[1:0] == 2'b00) chk("wdata", BUS_WDATA, e);
      end
      @(negedge CLOCK);
    end
    chk("left", q.size(), 0);
    chk("jump", JUMP_ADDR, ~(VECTOR_BASE + {22'h0, v, 2'b00}));
    chk("sp write", SP_WRITE, 1'b1);
    chk("sp new", SP_NEW, STACK_POINTER - 32'h8);
    chk("int ack", ia, {31'h0, intr});
    @(posedge CLOCK);
    #1;
    INT_REQ = 1'b0;
    @(negedge CLOCK);
    chk("busy end", EXC_BUSY, 1'b0);
  endtask

  initial begin
    #400000;
    err_total++;
    end_sim;
  end

  initial begin
    ARST_N = 1'b0;
    {DEC_VALID, DEC_UNDEF, DEC_DELAYED_BRANCH, DEC_PC_WRITE, DEC_TRAP} = 5'h0;
    {DEC_CTRL_XFER, INT_REQ, ADDR_ERR} = 3'h0;
    {DEC_ADDR, DEC_NEXT_PC, DEC_BRANCH_TARGET, DEC_TRAP_VEC} = 104'h0;
    void'($urandom(32'h45f03255));
    env;
    repeat (8) @(posedge CLOCK);
    #1;
    ARST_N = 1'b1;
    repeat (4) begin
      env;
      dec(0, 0, 1, 1, 0);
      exc(DEC_TRAP_VEC, DEC_NEXT_PC, 0);
      dec(1, 0, 0, 0, 0);
      exc(V_ILL, DEC_ADDR, 0);
      $display("test trap and illegal done");
      for (int k = 0; k < 3; k++) begin
        dec(0, 1, 1, 0, 0);
        tgt = DEC_BRANCH_TARGET;
        dec(k == 0, 0, k != 0, k == 2, 0);
        exc(V_SLOT, tgt, 0);
      end
      $display("test slot done");
      for (int m = 0; m < 2; m++) begin
        dec(0, m == 0, m == 0, 0, m == 1);
        dec(0, 0, 0, 0, 0);
        INT_REQ = 1'b1;
        none_taken;
        dec(0, 0, 0, 0, 0);
        exc(INT_VEC, DEC_ADDR, 1);
      end
      dec(0, 1, 1, 0, 0);
      // fault lands with the branch, so it is already pending at the slot decode
      ADDR_ERR = 1'b1;
      dec(0, 0, 0, 0, 0);
      none_taken;
      dec(0, 0, 0, 0, 0);
      exc(V_ADDR, DEC_ADDR, 0);
      dec(0, 0, 0, 0, 1);
      idle;
      ADDR_ERR = 1'b1;
      INT_REQ = 1'b1;
      dec(0, 0, 0, 0, 0);
      exc(V_ADDR, DEC_ADDR, 0);
      INT_REQ = 1'b1;
      dec(0, 0, 0, 0, 0);
      exc(INT_VEC, DEC_ADDR, 1);
      $display("test deferral done");
      STACK_POINTER[1:0] = 2'b10;
      dec(0, 0, 1, 1, 0);
      exc(DEC_TRAP_VEC, DEC_NEXT_PC, 0);
      dec(0, 0, 0, 0, 0);
      exc(V_ADDR, DEC_ADDR, 0);
      dec(0, 0, 0, 0, 0);
      none_taken;
      $display("test misaligned stack done");
    end
    end_sim;
  end
endmodule

`default_nettype wire
